// >>> logic/dcf_pkg.sv
// Shared constants, defaults and pointer helpers for the dual-clock buffer
package dcf_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 32;   // One word per transfer
  localparam int ADDR_W = 10;   // 1024 locations
  localparam int PTR_W = 11;    // Address plus wrap bit
  localparam logic [PTR_W-1:0] DEPTH = 11'h400;
  localparam logic [PTR_W-1:0] HALF_LEVEL = 11'h201;  // Depth/2 + 1
  localparam int CFG_W = 8;     // Synchronised configuration pins
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  // Eight default offsets, index {load_n, select_1, select_0}
  localparam logic [ADDR_W-1:0] DEF_OFFSET [8] = '{
    10'h007, 10'h00f, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff};

  // ------------------------------------------------------------
  // Gray conversion helpers
  // ------------------------------------------------------------
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// >>> logic/dcf_sync.sv
// Two-stage synchroniser for levels and gray-coded words
`timescale 1ns/10ps
module dcf_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic i_clock,
  // Level from the other domain
  input wire logic [W-1:0] i_async,
  // Synchronised level
  output logic [W-1:0] o_sync
);
  // ------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------
  logic [W-1:0] meta_reg;  // First stage, read only by the second

  // No reset: the chain settles within two edges of any clock
  always_ff @(posedge i_clock) begin
    meta_reg <= i_async;
    o_sync <= meta_reg;
  end
endmodule

// >>> logic/dcf_mem.sv
// Storage array: written on the write clock, read without a clock
`timescale 1ns/10ps
module dcf_mem (
  // Write port
  input wire logic i_clock,
  input wire logic i_write,
  input wire logic [dcf_pkg::ADDR_W-1:0] i_waddr,
  input wire logic [dcf_pkg::DATA_W-1:0] i_wdata,
  // Read port
  input wire logic [dcf_pkg::ADDR_W-1:0] i_raddr,
  output logic [dcf_pkg::DATA_W-1:0] o_rdata
);
  // ------------------------------------------------------------
  // Array
  // ------------------------------------------------------------
  logic [dcf_pkg::DATA_W-1:0] mem_reg [2**dcf_pkg::ADDR_W];

  // Write only when the caller has already checked for space
  always_ff @(posedge i_clock) begin
    if (i_write) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // Read location is only ever one the writer finished with
  assign o_rdata = mem_reg[i_raddr];
endmodule

// >>> logic/dcf_top.sv
// Dual-clock buffer with status flags, master reset and offset setup
//
// Behaviour
// - Empty flag low when no words stored
// - Full flag low when every location used
// - Half-full low from depth/2+1 words upward
// - Write and read data one 32-bit word
// - Reset samples selects and load: eight defaults
// - Reset zeroes both pointers and output register
// - Reset latches offsets, serial setup, flag timing
// - Output enable gates the read data drivers
// - Almost-empty low while count below empty offset
// - Almost-full low while free at/below offset
// - Timing select low async, high sync
// - Write clock stores word when write enabled and not full
//
`timescale 1ns/10ps
module dcf_top (
  // Write side clock and system reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Read side clock
  input wire logic i_read_clock,
  // Writer
  input wire logic i_write_en,
  input wire logic [dcf_pkg::DATA_W-1:0] i_write_data,
  // Reader
  input wire logic i_read_en,
  output logic [dcf_pkg::DATA_W-1:0] o_read_data,
  output logic o_read_data_oe,
  // Configuration pins
  input wire logic i_master_reset_n,
  input wire logic i_offset_select_0,
  input wire logic i_offset_select_1,
  input wire logic i_offset_load_n,
  input wire logic i_prog_flag_timing_sel,
  input wire logic i_serial_enable_n,
  input wire logic i_serial_in,
  input wire logic i_output_enable_n,
  // Status flags, all active low
  output logic o_empty_flag_n,
  output logic o_full_flag_n,
  output logic o_half_full_flag_n,
  output logic o_almost_empty_flag_n,
  output logic o_almost_full_flag_n
);
  // ------------------------------------------------------------
  // Write domain: pin synchronisation and reset
  // ------------------------------------------------------------
  logic [dcf_pkg::CFG_W-1:0] cfg_s;  // Synchronised pins
  logic mreset_n_s, fs0_s, fs1_s, load_n_s, timing_sel_s, ser_en_n_s, si_s, oe_unused;
  logic wrst_reg;                    // Registered master reset
  logic rst_w;                       // Write domain reset

  dcf_sync #(.W(dcf_pkg::CFG_W)) u_cfg_sync (
    .i_clock(i_clock),
    .i_async({i_master_reset_n, i_offset_select_0, i_offset_select_1, i_offset_load_n,
              i_prog_flag_timing_sel, i_serial_enable_n, i_serial_in, 1'b0}),
    .o_sync(cfg_s)
  );
  assign {mreset_n_s, fs0_s, fs1_s, load_n_s, timing_sel_s, ser_en_n_s, si_s, oe_unused} = cfg_s;

  // Registered so the read domain sees a clean level
  always_ff @(posedge i_clock) begin
    wrst_reg <= i_sys_rst | ~mreset_n_s;
  end
  assign rst_w = i_sys_rst | wrst_reg;

  // ------------------------------------------------------------
  // Write domain: configuration latched at master reset
  // ------------------------------------------------------------
  logic [dcf_pkg::ADDR_W-1:0] empty_off_reg;  // Almost-empty offset
  logic [dcf_pkg::ADDR_W-1:0] full_off_reg;   // Almost-full offset
  logic serial_mode_reg;                      // Serial loading allowed
  logic sync_timing_reg;                      // Programmable flag timing
  logic shift_en;                             // Serial bit this cycle
  logic loading_reg;                          // Reset or shifting was active
  logic cfg_tog_reg;                          // Offsets settled event

  // Load held high otherwise; only both low together shift a bit
  assign shift_en = serial_mode_reg & ~ser_en_n_s & ~load_n_s;

  // Defaults chosen by load and both selects while reset stands
  always_ff @(posedge i_clock) begin
    if (rst_w) begin
      empty_off_reg <= dcf_pkg::DEF_OFFSET[{load_n_s, fs1_s, fs0_s}];
      full_off_reg <= dcf_pkg::DEF_OFFSET[{load_n_s, fs1_s, fs0_s}];
      serial_mode_reg <= ~load_n_s;
      sync_timing_reg <= timing_sel_s;
    end else if (shift_en) begin
      // Full offset first, empty offset last; full offset shifts out of its top
      {full_off_reg, empty_off_reg} <= {full_off_reg[dcf_pkg::ADDR_W-2:0],
                                        empty_off_reg, si_s};
    end
  end

  // Toggle once offsets are stable: end of reset or of a load
  always_ff @(posedge i_clock) begin
    loading_reg <= rst_w | shift_en;
    if (i_sys_rst) begin
      cfg_tog_reg <= 1'b0;
    end else if (loading_reg & ~(rst_w | shift_en)) begin
      cfg_tog_reg <= ~cfg_tog_reg;
    end
  end

  // ------------------------------------------------------------
  // Write domain: pointer, count and flags
  // ------------------------------------------------------------
  logic [dcf_pkg::PTR_W-1:0] wbin_reg, wgray_reg, wbin_next;
  logic [dcf_pkg::PTR_W-1:0] rgray_s, rbin_s, wcount_next, wcount, wfree_next;
  logic do_write;
  logic ae_release_reg;  // Write side view: count at/over empty offset
  logic ae_release_s;    // Read side view of that level
  logic [dcf_pkg::PTR_W-1:0] rbin_reg, rgray_reg;  // Read pointer, needed here by the sync
  logic [dcf_pkg::DATA_W-1:0] mem_rdata;  // Stored word at the read pointer
  logic af_release_s;    // Write side view of the read side's release level

  dcf_sync #(.W(dcf_pkg::PTR_W)) u_rptr_sync (
    .i_clock(i_clock),
    .i_async(rgray_reg),
    .o_sync(rgray_s)
  );
  assign rbin_s = dcf_pkg::gray2bin(rgray_s);

  // Full refuses the write outright
  assign do_write = i_write_en & o_full_flag_n;
  assign wbin_next = wbin_reg + {10'h000, do_write};
  assign wcount_next = wbin_next - rbin_s;
  assign wcount = wbin_reg - rbin_s;
  assign wfree_next = dcf_pkg::DEPTH - wcount_next;

  // Store and advance on an enabled write edge
  always_ff @(posedge i_clock) begin
    if (rst_w) begin
      wbin_reg <= dcf_pkg::PTR_RST;
      wgray_reg <= dcf_pkg::PTR_RST;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= dcf_pkg::bin2gray(wbin_next);
    end
  end

  dcf_mem u_mem (
    .i_clock(i_clock),
    .i_write(do_write),
    .i_waddr(wbin_reg[dcf_pkg::ADDR_W-1:0]),
    .i_wdata(i_write_data),
    .i_raddr(rbin_reg[dcf_pkg::ADDR_W-1:0]),
    .o_rdata(mem_rdata)
  );

  // Flags from next pointers so a full write is never missed
  always_ff @(posedge i_clock) begin
    if (rst_w) begin
      o_full_flag_n <= 1'b1;
      o_half_full_flag_n <= 1'b1;
      o_almost_full_flag_n <= 1'b1;
      ae_release_reg <= 1'b0;
    end else begin
      o_full_flag_n <= (wcount_next != dcf_pkg::DEPTH);
      o_half_full_flag_n <= (wcount_next < dcf_pkg::HALF_LEVEL);
      ae_release_reg <= (wcount_next >= {1'b0, empty_off_reg});
      if (wfree_next <= {1'b0, full_off_reg}) begin
        o_almost_full_flag_n <= 1'b0;
      end else if (sync_timing_reg | af_release_s) begin
        // Asynchronous timing releases only on the read side's word
        o_almost_full_flag_n <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Read domain: reset, pins and settled configuration
  // ------------------------------------------------------------
  logic rst_r;          // Read domain reset
  logic [2:0] rcfg_s;   // Toggle, output enable, release level
  logic tog_s, oe_n_s, cfg_seen_reg;
  logic [dcf_pkg::ADDR_W-1:0] empty_off_r, full_off_r;
  logic sync_timing_r;

  dcf_sync #(.W(1)) u_rst_sync (
    .i_clock(i_read_clock),
    .i_async(rst_w),
    .o_sync(rst_r)
  );
  dcf_sync #(.W(3)) u_rcfg_sync (
    .i_clock(i_read_clock),
    .i_async({cfg_tog_reg, i_output_enable_n, ae_release_reg}),
    .o_sync(rcfg_s)
  );
  assign {tog_s, oe_n_s, ae_release_s} = rcfg_s;

  // Offsets were stable before the toggle, so a copy here is safe
  always_ff @(posedge i_read_clock) begin
    cfg_seen_reg <= tog_s;
    if (tog_s != cfg_seen_reg) begin
      empty_off_r <= empty_off_reg;
      full_off_r <= full_off_reg;
      sync_timing_r <= sync_timing_reg;
    end
  end

  // ------------------------------------------------------------
  // Read domain: pointer, output register and flags
  // ------------------------------------------------------------
  logic [dcf_pkg::PTR_W-1:0] rbin_next;
  logic [dcf_pkg::PTR_W-1:0] wgray_s, wbin_s, rcount_next, rcount, rfree_next;
  logic do_read;
  logic af_release_reg;  // Read side view: free over full offset

  dcf_sync #(.W(dcf_pkg::PTR_W)) u_wptr_sync (
    .i_clock(i_read_clock),
    .i_async(wgray_reg),
    .o_sync(wgray_s)
  );
  dcf_sync #(.W(1)) u_afr_sync (
    .i_clock(i_clock),
    .i_async(af_release_reg),
    .o_sync(af_release_s)
  );
  assign wbin_s = dcf_pkg::gray2bin(wgray_s);

  // Empty refuses the read outright
  assign do_read = i_read_en & o_empty_flag_n;
  assign rbin_next = rbin_reg + {10'h000, do_read};
  assign rcount_next = wbin_s - rbin_next;
  assign rcount = wbin_s - rbin_reg;
  assign rfree_next = dcf_pkg::DEPTH - rcount_next;

  // Pointer and output register cleared by master reset
  always_ff @(posedge i_read_clock) begin
    if (rst_r) begin
      rbin_reg <= dcf_pkg::PTR_RST;
      rgray_reg <= dcf_pkg::PTR_RST;
      o_read_data <= dcf_pkg::DATA_RST;
    end else begin
      rbin_reg <= rbin_next;
      rgray_reg <= dcf_pkg::bin2gray(rbin_next);
      if (do_read) begin
        o_read_data <= mem_rdata;
      end
    end
  end

  // Drivers follow the enable pin; idle drivers read as released
  always_ff @(posedge i_read_clock) begin
    o_read_data_oe <= ~oe_n_s;
  end

  // Empty and almost-empty live where reads happen
  always_ff @(posedge i_read_clock) begin
    if (rst_r) begin
      o_empty_flag_n <= 1'b0;
      o_almost_empty_flag_n <= 1'b0;
      af_release_reg <= 1'b1;
    end else begin
      o_empty_flag_n <= (rcount_next != dcf_pkg::PTR_RST);
      af_release_reg <= (rfree_next > {1'b0, full_off_r});
      if (rcount_next < {1'b0, empty_off_r}) begin
        o_almost_empty_flag_n <= 1'b0;
      end else if (sync_timing_r | ae_release_s) begin
        // Asynchronous timing releases only on the write side's word
        o_almost_empty_flag_n <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_EMPTY_SHOWN: assert property (
    @(posedge i_read_clock) disable iff (rst_r)
    (rcount == dcf_pkg::PTR_RST) && $past(!rst_r) |-> !o_empty_flag_n)
    else $error("empty flag high with no words stored");

  AST_FULL_SHOWN: assert property (
    @(posedge i_clock) disable iff (rst_w)
    (wcount == dcf_pkg::DEPTH) |-> !o_full_flag_n)
    else $error("full flag high with every location used");

  AST_HALF_SHOWN: assert property (
    @(posedge i_clock) disable iff (rst_w)
    (wcount >= dcf_pkg::HALF_LEVEL) && $past(!rst_w) |-> !o_half_full_flag_n)
    else $error("half-full flag high above half depth");

  AST_NO_WRITE_WHEN_FULL: assert property (
    @(posedge i_clock) disable iff (rst_w)
    !o_full_flag_n |=> (wbin_reg == $past(wbin_reg)))
    else $error("write pointer moved while full");

  AST_WRITE_ADVANCES: assert property (
    @(posedge i_clock) disable iff (rst_w)
    i_write_en && o_full_flag_n |=> (wbin_reg == $past(wbin_reg) + 11'h001))
    else $error("enabled write did not store a word");

  AST_RESET_CLEARS: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    rst_w ##1 rst_w |-> (wbin_reg == dcf_pkg::PTR_RST) && (wgray_reg == dcf_pkg::PTR_RST))
    else $error("master reset left write pointer set");

  AST_OFFSET_HELD: assert property (
    @(posedge i_clock) disable iff (rst_w)
    !shift_en |=> $stable(empty_off_reg) && $stable(full_off_reg) && $stable(sync_timing_reg))
    else $error("latched configuration changed without loading");

  AST_AE_LOW: assert property (
    @(posedge i_read_clock) disable iff (rst_r)
    (rcount_next < {1'b0, empty_off_r}) |=> !o_almost_empty_flag_n)
    else $error("almost-empty high below empty offset");

  AST_AF_LOW: assert property (
    @(posedge i_clock) disable iff (rst_w)
    (wfree_next <= {1'b0, full_off_reg}) |=> !o_almost_full_flag_n)
    else $error("almost-full high at or below full offset");

  AST_OE_FOLLOWS: assert property (
    @(posedge i_read_clock) disable iff (rst_r)
    oe_n_s [*2] |-> !o_read_data_oe)
    else $error("read drivers enabled while output enable inactive");
endmodule

// >>> bench/dcf_reader_model.sv
// Reader-side partner: streams reads on the read clock and checks word order
`timescale 1ns/10ps
module dcf_reader_model #(
  parameter logic [31:0] BASE = 32'h5a00_0000
) (
  // Read clock and clear
  input wire logic i_read_clock,
  input wire logic i_clear,
  // Bench control
  input wire logic i_go,
  // Design read side
  input wire logic i_empty_flag_n,
  input wire logic [dcf_pkg::DATA_W-1:0] i_read_data,
  output logic o_read_en,
  // Results
  output logic [31:0] o_count,
  output logic o_order_ok
);
  logic took_reg; // A read was accepted at the previous edge

  // --------------------------------------------------------------
  // Read stream
  // --------------------------------------------------------------
  // Reads keep going while empty; the design must refuse them
  always_ff @(posedge i_read_clock) begin
    if (i_clear) begin
      o_read_en <= 1'b0;
      took_reg <= 1'b0;
      o_count <= 32'h0;
      o_order_ok <= 1'b1;
    end else begin
      o_read_en <= i_go;
      took_reg <= o_read_en && (i_empty_flag_n === 1'b1);
      // Data stands until the next accepted read, so pre-edge value is ours
      if (took_reg) begin
        o_count <= o_count + 32'h1;
        if (i_read_data !== BASE + o_count) begin
          o_order_ok <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> bench/dual_clock_fifo_flags_reset_bench.sv
// Self-checking bench for the dual-clock buffer flags and reset setup
`timescale 1ns/10ps
module dual_clock_fifo_flags_reset_bench;
  localparam logic [31:0] BASE = 32'h5a00_0000; // Word k carries BASE+k
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk = 1'b0; // Write clock, 10 ns
  logic rclk = 1'b0; // Read clock, 6 ns
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic [dcf_pkg::DATA_W-1:0] wr_data = '0;
  logic mrst_n = 1'b1;
  logic sel0 = 1'b0;
  logic sel1 = 1'b0;
  logic load_n = 1'b1;
  logic timing_sel = 1'b1;
  logic ser_en_n = 1'b1;
  logic ser_in = 1'b0;
  logic oe_n = 1'b0;
  logic go = 1'b0;
  logic clr = 1'b1;
  logic rd_en;
  logic [dcf_pkg::DATA_W-1:0] rd_data;
  logic rd_oe, empty_n, full_n, half_n, ae_n, af_n, ok;
  logic [31:0] cnt;
  int fail_count = 0;
  int checked = 0;
  int wcount = 0; // Words offered by the writer since reset
  int cycles = 0;

  initial begin
    forever #5 clk = ~clk;
  end
  // Phase offset keeps the two domains unrelated
  initial begin
    #1.3;
    forever #3 rclk = ~rclk;
  end

  dcf_top dcf_top_inst (.i_clock(clk), .i_sys_rst(sys_rst), .i_read_clock(rclk),
    .i_write_en(wr_en), .i_write_data(wr_data), .i_read_en(rd_en), .o_read_data(rd_data),
    .o_read_data_oe(rd_oe), .i_master_reset_n(mrst_n), .i_offset_select_0(sel0),
    .i_offset_select_1(sel1), .i_offset_load_n(load_n), .i_prog_flag_timing_sel(timing_sel),
    .i_serial_enable_n(ser_en_n), .i_serial_in(ser_in), .i_output_enable_n(oe_n),
    .o_empty_flag_n(empty_n), .o_full_flag_n(full_n), .o_half_full_flag_n(half_n),
    .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n));

  dcf_reader_model #(.BASE(BASE)) dcf_reader_model_inst (.i_read_clock(rclk),
    .i_clear(clr), .i_go(go), .i_empty_flag_n(empty_n), .i_read_data(rd_data),
    .o_read_en(rd_en), .o_count(cnt), .o_order_ok(ok));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("counts: %0d checked, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Back-to-back words, one per write edge
  task automatic write_n(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_en <= 1'b1;
      wr_data <= BASE + wcount;
      wcount++;
    end
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Expected flags from word count and offsets; waits out the read-side sync
  task automatic check_flags(input int n, input int off_e, input int off_f);
    repeat (12) @(posedge clk);
    check(empty_n, n != 0, "empty flag");
    check(full_n, n != 1024, "full flag");
    check(half_n, n < int'(dcf_pkg::HALF_LEVEL), "half-full flag");
    check(ae_n, n >= off_e, "almost-empty flag");
    check(af_n, (1024 - n) > off_f, "almost-full flag");
  endtask

  // Master reset with configuration pins held through it
  task automatic reset_cfg(input logic [2:0] idx, input logic timing);
    @(posedge clk);
    {mrst_n, load_n, sel1, sel0, timing_sel, clr} <= {1'b0, idx, timing, 1'b1};
    repeat (8) @(posedge clk);
    mrst_n <= 1'b1;
    clr <= 1'b0;
    @(posedge clk);
    load_n <= 1'b1; // Load stays high once reset ends
    wcount = 0;
    repeat (12) @(posedge clk);
  endtask

  // Stream reads until n words arrived, bounded wait
  task automatic drain(input int n);
    go <= 1'b1;
    for (int i = 0; i < 4000 && cnt != n; i++) begin
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
    go <= 1'b0;
    check(cnt, n, "words read");
    check(ok, 1'b1, "word order");
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_defaults();
    int off;
    // Every select and load code picks its own default offset
    for (int idx = 0; idx < 8; idx++) begin
      reset_cfg(idx[2:0], 1'b1);
      off = int'(dcf_pkg::DEF_OFFSET[idx]);
      write_n(off - 1);
      check_flags(off - 1, off, off);
      write_n(1);
      check_flags(off, off, off);
    end
    $display("test defaults done");
  endtask

  task automatic test_fill();
    int steps[7] = '{126, 1, 385, 1, 383, 1, 127};
    int n;
    reset_cfg(3'h4, 1'b1);
    n = 0;
    // Counts straddle each threshold: 127 offset, 513 half, full
    foreach (steps[i]) begin
      write_n(steps[i]);
      n += steps[i];
      check_flags(n, 127, 127);
    end
    write_n(1);
    wcount--; // Refused while full
    check_flags(1024, 127, 127);
    drain(1024);
    check(rd_data, BASE + 1023, "last word held after refused reads");
    check_flags(0, 127, 127);
    reset_cfg(3'h4, 1'b1);
    check(rd_data, 32'h0, "output register cleared");
    check_flags(0, 127, 127);
    $display("test fill done");
  endtask

  task automatic test_serial();
    logic [19:0] val;
    val = {10'h005, 10'h003}; // Full offset 5, empty offset 3
    reset_cfg(3'h0, 1'b0); // Serial mode, async flag timing
    for (int i = 19; i >= 0; i--) begin
      @(posedge clk);
      {ser_en_n, load_n, ser_in} <= {2'b00, val[i]}; // Load low only with enable
    end
    @(posedge clk);
    {ser_en_n, load_n} <= 2'b11;
    repeat (12) @(posedge clk);
    write_n(2);
    check_flags(2, 3, 5);
    write_n(1);
    check_flags(3, 3, 5);
    drain(3); // Pointers restarted at zero
    check_flags(0, 3, 5);
    $display("test serial done");
  endtask

  task automatic test_oe();
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(rd_oe, 1'b0, "outputs released");
    oe_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(rd_oe, 1'b1, "outputs driven");
    $display("test output enable done");
  endtask

  // --------------------------------------------------------------
  // Main sequence and hang guard
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    clr <= 1'b0;
    check_flags(0, 127, 127);
    check(rd_data, 32'h0, "output register after reset");
    test_oe();
    test_defaults();
    test_fill();
    test_serial();
    stop_test();
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end
endmodule
